// *** ext_sram.sv ***
/*
 Model of an external static RAM behind an address latch on port 0/2.
 Assumes the block's bus outputs are registered on the same clock.
*/
`timescale 1ns/1ps
module ext_sram
  import offchip_data_space_map_pkg::*;
(
  input  wire logic     i_clk,
  input  wire ext_bus_s i_bus,
  output logic [7:0]    o_drv
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_ff;
  logic [7:0] last_ff = 8'h00;
  // Latch loads port 0 on each clock edge while the strobe is high
  always @(posedge i_clk) begin
    if (i_bus.ale) lat_ff <= i_bus.p0_out;
    if (!i_bus.wr_n) mem[{i_bus.p2_out, lat_ff}] <= i_bus.p0_out;
    if (!i_bus.rd_n) last_ff <= mem[{i_bus.p2_out, lat_ff}];
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  assign o_drv = !i_bus.rd_n ? mem[{i_bus.p2_out, lat_ff}] : ~last_ff;
endmodule : ext_sram

// *** offchip_data_space_bus_stack_iap_map.sv ***
/*
 External data bus engine, stack placement and self-programming address
 router, with its control registers on Avalon-MM. Assumes the core holds
 a request until done, and that flash programming itself lives outside,
 answering on the nonvolatile port.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module offchip_data_space_bus_stack_iap_map
  import offchip_data_space_map_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [9:0] i_avs_address,
  input  wire logic       i_avs_read,
  input  wire logic       i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0] i_avs_byteenable,
  output logic [31:0]     o_avs_readdata,
  output logic            o_avs_waitrequest,
  input  wire core_req_s  i_core_req,
  output core_rsp_s       o_core_rsp,
  output logic            o_cpu_idle,
  input  wire logic       i_self_prog_fuse,
  output nv_req_s         o_nv_req,
  input  wire logic       i_nv_ack,
  input  wire logic [7:0] i_nv_rdata,
  output ext_bus_s        o_ext_bus,
  input  wire logic [7:0] i_p0_in,
  input  wire logic [7:0] i_p0_port_out,
  input  wire logic [7:0] i_p0_port_oe
);

  bus_state_e  state_ff;
  bus_state_e  nxt_state;
  logic [7:0]  stack_ptr_ff;
  logic [7:0]  stack_page_ff;
  logic [7:0]  aux_ctrl_ff;
  logic [7:0]  mem_ctrl_ff;
  logic        waitreq_ff;
  logic [31:0] readdata_ff;
  logic [7:0]  rdata_ff;
  logic        done_ff;
  logic        cpu_idle_ff;
  nv_req_s     nv_req_ff;
  ext_bus_s    ext_ff;
  logic [1:0]  strobe_cnt_ff;
  logic [15:0] acc_addr_ff;
  logic [7:0]  acc_wdata_ff;
  logic        acc_write_ff;
  logic [7:0]  xram [0:XRAM_WORDS-1];
  logic [7:0]  indirect_ram_space [0:INDIRECT_RAM_SPACE_WORDS-1];

  logic        bus_req;
  logic        bus_take;
  logic [7:0]  bus_idx;
  logic        wide_stack;
  logic        offchip;
  logic        self_prog;
  logic        user_id;
  logic        flash_data;
  logic        latch_idle;
  logic [1:0]  wait_sel;
  logic        start;
  logic        is_stack;
  logic [7:0]  stack_slot;
  logic [15:0] route_addr;
  target_e     target;
  nv_space_e   nv_space;

  assign wide_stack = aux_ctrl_ff[AUX_WIDE_STACK];
  assign offchip    = aux_ctrl_ff[AUX_OFFCHIP];
  assign latch_idle = aux_ctrl_ff[AUX_LATCH_IDLE];
  assign wait_sel   = aux_ctrl_ff[AUX_WAIT_HI:AUX_WAIT_LO];
  // Fuse gates the bit at use as well, so a late fuse change is safe
  assign self_prog  = mem_ctrl_ff[MEM_SELF_PROG] & i_self_prog_fuse;
  assign user_id    = mem_ctrl_ff[MEM_USER_ID];
  assign flash_data = mem_ctrl_ff[MEM_FLASH_DATA];

  assign bus_req  = i_avs_read | i_avs_write;
  assign bus_take = bus_req & ~waitreq_ff;
  assign bus_idx  = i_avs_address[9:2];
  assign start    = (state_ff == ST_IDLE) & i_core_req.valid;
  assign is_stack = (i_core_req.kind == REQ_PUSH) | (i_core_req.kind == REQ_POP);

  // Push pre-increments, pop reads the current slot; 8 bits wrap alone
  assign stack_slot = (i_core_req.kind == REQ_PUSH) ? stack_ptr_ff + 8'h01
                                                    : stack_ptr_ff;

  always_comb begin
    nv_space = NV_CODE;
    target   = TGT_EXT;
    route_addr = i_core_req.addr;
    case (i_core_req.kind)
      REQ_PUSH, REQ_POP: begin
        if (wide_stack) begin
          // Extended stack ignores the offchip flag
          target     = TGT_XRAM;
          route_addr = {4'h0, stack_page_ff[3:0], stack_slot};
        end else begin
          target     = TGT_INDIRECT_RAM_SPACE;
          route_addr = {8'h00, stack_slot};
        end
      end
      REQ_CODE_READ: begin
        target   = TGT_NV;
        nv_space = user_id ? NV_SIG : NV_CODE;
      end
      REQ_XMOVE_DPTR: begin
        if (self_prog) begin
          target   = TGT_NV;
          nv_space = user_id ? NV_SIG : NV_CODE;
        end else if (offchip) begin
          target = TGT_EXT;
        end else if (i_core_req.addr <= XRAM_LAST) begin
          target = TGT_XRAM;
        end else if (flash_data && i_core_req.addr >= FLASH_DATA_SPACE_FIRST &&
                     i_core_req.addr <= FLASH_DATA_SPACE_LAST) begin
          target   = TGT_NV;
          nv_space = NV_FLASH_DATA;
        end else begin
          target = TGT_EXT;
        end
      end
      REQ_XMOVE_PAGED: begin
        if (!offchip && i_core_req.addr <= XRAM_LAST) begin
          target = TGT_XRAM;
        end else begin
          target = TGT_EXT;
        end
      end
      default: begin
        target = TGT_EXT;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_core_req.valid) begin
          case (target)
            TGT_INDIRECT_RAM_SPACE: nxt_state = ST_DONE;
            TGT_XRAM:  nxt_state = is_stack ? ST_STK_WAIT : ST_DONE;
            TGT_NV:    nxt_state = ST_NV;
            default:   nxt_state = ST_LATCH;
          endcase
        end
      end
      ST_STK_WAIT: nxt_state = ST_DONE;
      ST_LATCH:    nxt_state = ST_HOLD;
      ST_HOLD:     nxt_state = ST_STROBE;
      ST_STROBE:   nxt_state = (strobe_cnt_ff == 2'h0) ? ST_DONE : ST_STROBE;
      ST_NV:       nxt_state = i_nv_ack ? ST_DONE : ST_NV;
      ST_DONE:     nxt_state = ST_IDLE;
      default:     nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Avalon slave: one wait cycle, then a one-cycle answer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else if (bus_req && waitreq_ff) begin
      waitreq_ff <= 1'b0;
      case (bus_idx)
        IDX_STACK_PTR:  readdata_ff <= {24'h000000, stack_ptr_ff};
        IDX_STACK_PAGE: readdata_ff <= {24'h000000, stack_page_ff};
        IDX_AUX_CTRL:   readdata_ff <= {24'h000000, aux_ctrl_ff};
        IDX_MEM_CTRL:   readdata_ff <= {24'h000000, mem_ctrl_ff};
        default:        readdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      waitreq_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aux_ctrl_ff   <= RST_ZERO;
      mem_ctrl_ff   <= RST_ZERO;
      stack_page_ff <= RST_ZERO;
    end else begin
      if (bus_take && i_avs_write && i_avs_byteenable[0]) begin
        case (bus_idx)
          IDX_AUX_CTRL:   aux_ctrl_ff   <= i_avs_writedata[7:0] & AUX_WMASK;
          IDX_STACK_PAGE: stack_page_ff <= {4'h0, i_avs_writedata[3:0] & STACK_PAGE_MASK};
          IDX_MEM_CTRL: begin
            mem_ctrl_ff <= i_avs_writedata[7:0] & MEM_WMASK;
          end
          default: ;
        endcase
      end
      if (!i_self_prog_fuse) begin
        mem_ctrl_ff[MEM_SELF_PROG] <= 1'b0;
      end
    end
  end

  // Software write wins over a stack step in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stack_ptr_ff <= RST_STACK_PTR;
    end else if (bus_take && i_avs_write && i_avs_byteenable[0] &&
                 bus_idx == IDX_STACK_PTR) begin
      stack_ptr_ff <= i_avs_writedata[7:0];
    end else if (start && is_stack) begin
      if (i_core_req.kind == REQ_PUSH) begin
        stack_ptr_ff <= stack_ptr_ff + 8'h01;
      end else begin
        stack_ptr_ff <= stack_ptr_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (start && i_core_req.write && target == TGT_XRAM) begin
      xram[route_addr[11:0]] <= i_core_req.wdata;
    end
    if (start && i_core_req.write && target == TGT_INDIRECT_RAM_SPACE) begin
      indirect_ram_space[route_addr[7:0]] <= i_core_req.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= RST_ZERO;
    end else if (start && target == TGT_XRAM) begin
      rdata_ff <= xram[route_addr[11:0]];
    end else if (start && target == TGT_INDIRECT_RAM_SPACE) begin
      rdata_ff <= indirect_ram_space[route_addr[7:0]];
    end else if (state_ff == ST_NV && i_nv_ack) begin
      rdata_ff <= i_nv_rdata;
    end else if (state_ff == ST_STROBE && strobe_cnt_ff == 2'h0 && !acc_write_ff) begin
      rdata_ff <= i_p0_in;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (nxt_state == ST_DONE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc_addr_ff  <= 16'h0000;
      acc_wdata_ff <= RST_ZERO;
      acc_write_ff <= 1'b0;
    end else if (start) begin
      acc_addr_ff  <= route_addr;
      acc_wdata_ff <= i_core_req.wdata;
      acc_write_ff <= i_core_req.write;
    end
  end

  // Nonvolatile port; program and signature writes park the CPU
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      nv_req_ff   <= '0;
      cpu_idle_ff <= 1'b0;
    end else if (start && target == TGT_NV) begin
      nv_req_ff.valid <= 1'b1;
      nv_req_ff.space <= nv_space;
      nv_req_ff.write <= i_core_req.write;
      nv_req_ff.addr  <= (nv_space == NV_SIG) ? (i_core_req.addr & SIG_LAST)
                                              : i_core_req.addr;
      nv_req_ff.wdata <= i_core_req.wdata;
      cpu_idle_ff     <= i_core_req.write && (nv_space != NV_FLASH_DATA);
    end else if (state_ff == ST_NV && i_nv_ack) begin
      nv_req_ff.valid <= 1'b0;
      cpu_idle_ff     <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strobe_cnt_ff <= 2'h0;
    end else if (state_ff == ST_HOLD) begin
      strobe_cnt_ff <= wait_sel;
    end else if (state_ff == ST_STROBE && strobe_cnt_ff != 2'h0) begin
      strobe_cnt_ff <= strobe_cnt_ff - 2'h1;
    end
  end

  // External pins follow the next state so every pin comes from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_ff.ale    <= 1'b1;
      ext_ff.rd_n   <= 1'b1;
      ext_ff.wr_n   <= 1'b1;
      ext_ff.p0_out <= RST_ZERO;
      ext_ff.p0_oe  <= RST_ZERO;
      ext_ff.p2_out <= RST_ZERO;
    end else begin
      case (nxt_state)
        ST_LATCH: begin
          ext_ff.ale    <= 1'b1;
          ext_ff.p0_out <= route_addr[7:0];
          ext_ff.p0_oe  <= 8'hff;
          ext_ff.p2_out <= route_addr[15:8];
        end
        ST_HOLD: begin
          // Address stays put across the latch falling edge
          ext_ff.ale <= 1'b0;
        end
        ST_STROBE: begin
          ext_ff.ale <= 1'b0;
          if (acc_write_ff) begin
            ext_ff.p0_out <= acc_wdata_ff;
            ext_ff.p0_oe  <= 8'hff;
            ext_ff.wr_n   <= 1'b0;
          end else begin
            ext_ff.p0_oe <= 8'h00;
            ext_ff.rd_n  <= 1'b0;
          end
        end
        default: begin
          ext_ff.ale    <= ~latch_idle;
          ext_ff.rd_n   <= 1'b1;
          ext_ff.wr_n   <= 1'b1;
          ext_ff.p0_out <= i_p0_port_out;
          ext_ff.p0_oe  <= i_p0_port_oe;
        end
      endcase
    end
  end

  assign o_avs_readdata    = readdata_ff;
  assign o_avs_waitrequest = waitreq_ff;
  assign o_core_rsp        = '{done: done_ff, rdata: rdata_ff};
  assign o_cpu_idle        = cpu_idle_ff;
  assign o_nv_req          = nv_req_ff;
  assign o_ext_bus         = ext_ff;

endmodule : offchip_data_space_bus_stack_iap_map

// *** offchip_data_space_map_assertions.sv ***
/*
 Concurrent checks on the ports of the external bus and address map block.
 Assumes one clock and that register writes reach the block over Avalon-MM.
*/
`timescale 1ns/1ps
module offchip_data_space_map_checker
  import offchip_data_space_map_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [9:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire core_req_s   i_core_req,
  input wire core_rsp_s   o_core_rsp,
  input wire logic        o_cpu_idle,
  input wire logic        i_self_prog_fuse,
  input wire nv_req_s     o_nv_req,
  input wire ext_bus_s    o_ext_bus,
  input wire logic [7:0]  i_p0_port_oe
);
  logic [1:0] ws_ff;
  logic       latch_idle_level_ff;
  logic [2:0] cnt_ff;
  wire aux_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                && (i_avs_address[9:2] == IDX_AUX_CTRL);
  wire strobe = !o_ext_bus.rd_n || !o_ext_bus.wr_n;
  // Shadow of the control bits, taken at the same edge as the block
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ws_ff <= 2'h0;
      latch_idle_level_ff <= 1'b0;
    end else if (aux_wr) begin
      ws_ff <= i_avs_writedata[3:2];
      latch_idle_level_ff <= i_avs_writedata[0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !strobe) cnt_ff <= 3'h0;
    else cnt_ff <= cnt_ff + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_strobe_width: assert property (($rose(o_ext_bus.rd_n) || $rose(o_ext_bus.wr_n))
    |-> cnt_ff == {1'b0, ws_ff} + 3'h1) else $error("strobe width wrong");
  chk_ale_rest: assert property (o_core_rsp.done |-> o_ext_bus.ale == !latch_idle_level_ff)
    else $error("latch strobe idle level wrong");
  chk_ale_pulse: assert property ($rose(o_ext_bus.ale) && latch_idle_level_ff
    |=> !o_ext_bus.ale ##1 strobe) else $error("latch strobe outside access");
  chk_addr_latch: assert property ($fell(o_ext_bus.ale) && o_ext_bus.p0_oe == 8'hff
    |-> $stable(o_ext_bus.p0_out) && $stable(o_ext_bus.p2_out)) else $error("address moved");
  chk_read_float: assert property (!o_ext_bus.rd_n |-> o_ext_bus.p0_oe == 8'h00)
    else $error("port 0 driven during read");
  chk_write_drive: assert property (!o_ext_bus.wr_n |-> o_ext_bus.p0_oe == 8'hff)
    else $error("port 0 not driven during write");
  chk_p0_idle: assert property (o_core_rsp.done |-> o_ext_bus.p0_oe == $past(i_p0_port_oe))
    else $error("port 0 idle enable wrong");
  chk_stack_local: assert property (i_core_req.valid && i_core_req.kind inside {REQ_PUSH, REQ_POP}
    |-> o_ext_bus.rd_n && o_ext_bus.wr_n) else $error("stack went external");
  chk_prog_idle: assert property ($rose(o_cpu_idle) |-> o_nv_req.valid && o_nv_req.write
    && o_nv_req.space != NV_FLASH_DATA) else $error("idle without program write");
  chk_sig_range: assert property (o_nv_req.valid && o_nv_req.space == NV_SIG
    |-> o_nv_req.addr <= SIG_LAST) else $error("signature address out of range");
  chk_fuse_gate: assert property (i_avs_read && !o_avs_waitrequest && !i_self_prog_fuse
    && i_avs_address[9:2] == IDX_MEM_CTRL |-> !o_avs_readdata[7]) else $error("self program bit set");
  cover property ($rose(o_ext_bus.rd_n));
  cover property ($rose(o_cpu_idle));
  cover property (i_core_req.valid && i_core_req.kind == REQ_PUSH && o_core_rsp.done);
endmodule : offchip_data_space_map_checker
bind offchip_data_space_bus_stack_iap_map offchip_data_space_map_checker chk_i (.*);

// *** offchip_data_space_map_pkg.sv ***
/*
 Shared constants and carriers for the external data bus, stack placement
 and self-programming address map. Assumes one 100 MHz core clock.
*/
package offchip_data_space_map_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [7:0] IDX_STACK_PTR = 8'h81;
  localparam logic [7:0] IDX_STACK_PAGE = 8'h9e;
  localparam logic [7:0] IDX_AUX_CTRL = 8'h8e;
  localparam logic [7:0] IDX_MEM_CTRL = 8'h96;
  localparam logic [7:0] RST_STACK_PTR = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] STACK_PAGE_MASK = 4'hf;
  // Control register fields
  localparam int AUX_WIDE_STACK = 4;
  localparam int AUX_WAIT_HI = 3;
  localparam int AUX_WAIT_LO = 2;
  localparam int AUX_OFFCHIP = 1;
  localparam int AUX_LATCH_IDLE = 0;
  localparam int MEM_SELF_PROG = 7;
  localparam int MEM_FLASH_DATA = 3;
  localparam int MEM_USER_ID = 2;
  localparam logic [7:0] AUX_WMASK = 8'h1f;
  localparam logic [7:0] MEM_WMASK = 8'h8c;
  // Address map bounds
  localparam logic [15:0] XRAM_LAST = 16'h0fff;
  localparam logic [15:0] FLASH_DATA_SPACE_FIRST = 16'h1000;
  localparam logic [15:0] FLASH_DATA_SPACE_LAST = 16'h2fff;
  localparam logic [15:0] SIG_LAST = 16'h01ff;
  localparam int XRAM_WORDS = 4096;
  localparam int INDIRECT_RAM_SPACE_WORDS = 256;

  typedef enum logic [2:0] {
    REQ_XMOVE_DPTR = 3'h0,
    REQ_XMOVE_PAGED = 3'h1,
    REQ_CODE_READ = 3'h2,
    REQ_PUSH = 3'h3,
    REQ_POP = 3'h4
  } req_kind_e;

  typedef enum logic [1:0] {
    NV_CODE = 2'h0,
    NV_SIG = 2'h1,
    NV_FLASH_DATA = 2'h2
  } nv_space_e;

  typedef enum logic [1:0] {
    TGT_INDIRECT_RAM_SPACE = 2'h0,
    TGT_XRAM = 2'h1,
    TGT_NV = 2'h2,
    TGT_EXT = 2'h3
  } target_e;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_STK_WAIT = 7'h02,
    ST_LATCH = 7'h04,
    ST_HOLD = 7'h08,
    ST_STROBE = 7'h10,
    ST_NV = 7'h20,
    ST_DONE = 7'h40
  } bus_state_e;

  typedef struct packed {
    logic        valid;
    req_kind_e   kind;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } core_req_s;

  typedef struct packed {
    logic        done;
    logic [7:0]  rdata;
  } core_rsp_s;

  typedef struct packed {
    logic        valid;
    nv_space_e   space;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nv_req_s;

  typedef struct packed {
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  p0_out;
    logic [7:0]  p0_oe;
    logic [7:0]  p2_out;
  } ext_bus_s;
endpackage : offchip_data_space_map_pkg

// *** testbench.sv ***
/*
 Self-checking bench for the external bus, stack and address map block.
 Assumes the SRAM model and the checker bound onto the block.
*/
`timescale 1ns/1ps
module testbench;
  import offchip_data_space_map_pkg::*;
  logic i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, fuse = 1, ack = 0, wq, idle;
  logic [9:0] adr = '0;
  logic [31:0] wd = '0, q;
  logic [7:0] nvd = '0, drv, pin, v;
  core_req_s req = '0;
  core_rsp_s rsp;
  nv_req_s nv;
  ext_bus_s bus;
  nv_space_e sp;
  int n_fail = 0, tests_run = 0, cyc = 0, n_ext = 0, dly = 0, n_idle = 0, n, n0, n1;
  always #5 i_clk = ~i_clk;
  assign pin = (bus.p0_oe & bus.p0_out) | (~bus.p0_oe & drv);
  offchip_data_space_bus_stack_iap_map dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(q), .o_avs_waitrequest(wq), .i_core_req(req), .o_core_rsp(rsp),
    .o_cpu_idle(idle), .i_self_prog_fuse(fuse), .o_nv_req(nv), .i_nv_ack(ack),
    .i_nv_rdata(nvd), .o_ext_bus(bus), .i_p0_in(pin), .i_p0_port_out(8'ha5),
    .i_p0_port_oe(8'h0f));
  // Strobe and port 2 pins reach the RAM as plain outputs, as software must set them
  ext_sram sram (.i_clk(i_clk), .i_bus(bus), .o_drv(drv));
  // Slow nonvolatile side: answers four cycles after the request
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    ack <= 1'b0;
    if (!bus.wr_n || !bus.rd_n) n_ext <= n_ext + 1;
    if (nv.valid && idle) n_idle <= n_idle + 1;
    if (nv.valid && !ack) begin
      dly <= dly + 1;
      if (dly == 3) begin
        ack <= 1'b1;
        nvd <= nv.addr[7:0] ^ 8'h5a;
        sp <= nv.space;
        dly <= 0;
      end
    end
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    adr <= {idx, 2'h0};
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge i_clk); while (wq !== 1'b0);
    v = q[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  task automatic core(input req_kind_e k, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge i_clk);
    req <= '{1'b1, k, w, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.done !== 1'b1);
    v = rsp.rdata;
    req.valid <= 1'b0;
  endtask : core
  task automatic t_regs;
    av(0, IDX_STACK_PTR, 0); chk(v, RST_STACK_PTR);
    av(0, IDX_AUX_CTRL, 0); chk(v, RST_ZERO);
    av(1, IDX_AUX_CTRL, 8'hff); av(0, IDX_AUX_CTRL, 0); chk(v, 8'h1f);
    av(1, IDX_STACK_PAGE, 8'hff); av(0, IDX_STACK_PAGE, 0); chk(v, 8'h0f);
    av(1, 8'h10, 8'h55); av(0, 8'h10, 0); chk(v, 8'h00);
    av(1, IDX_AUX_CTRL, 0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ext;
    for (int a = 0; a < 2; a++) for (int w = 0; w < 4; w++) begin
      av(1, IDX_AUX_CTRL, 8'(w * 4 + 2 + a));
      core(REQ_XMOVE_DPTR, 1, {8'h40 + 8'(w), 8'h10 + 8'(a)}, 8'hc0 + 8'(w));
      chk(n, 5 + w);
      chk({bus.p0_oe, bus.p0_out}, 16'h0fa5);
      chk(bus.ale, !a);
      core(REQ_XMOVE_DPTR, 0, {8'h40 + 8'(w), 8'h10 + 8'(a)}, 0);
      chk(v, 8'hc0 + 8'(w));
      chk(n, 5 + w);
    end
    $display("test external done");
  endtask : t_ext
  task automatic t_map;
    av(1, IDX_AUX_CTRL, 8'h00);
    n0 = n_ext;
    core(REQ_XMOVE_DPTR, 1, 16'h0100, 8'h3c);
    chk(n_ext, n0);
    core(REQ_XMOVE_DPTR, 1, 16'h5000, 8'h77);
    chk(sram.mem[16'h5000], 8'h77);
    av(1, IDX_AUX_CTRL, 8'h02);
    core(REQ_XMOVE_DPTR, 1, 16'h0100, 8'h99);
    chk(sram.mem[16'h0100], 8'h99);
    core(REQ_XMOVE_PAGED, 1, 16'h0220, 8'h5e);
    chk(sram.mem[16'h0220], 8'h5e);
    av(1, IDX_AUX_CTRL, 8'h00);
    n0 = n_ext;
    core(REQ_XMOVE_PAGED, 1, 16'h0330, 8'h21);
    chk(n_ext, n0);
    core(REQ_XMOVE_DPTR, 0, 16'h0330, 0); chk(v, 8'h21);
    core(REQ_XMOVE_DPTR, 0, 16'h0100, 0); chk(v, 8'h3c);
    $display("test map done");
  endtask : t_map
  task automatic t_stack;
    av(1, IDX_STACK_PAGE, 8'h05);
    core(REQ_PUSH, 1, 0, 8'h11);
    n0 = n;
    core(REQ_PUSH, 1, 0, 8'h22);
    av(0, IDX_STACK_PTR, 0); chk(v, 8'h09);
    av(1, IDX_STACK_PAGE, 8'h0a);
    core(REQ_POP, 0, 0, 0); chk(v, 8'h22);
    core(REQ_POP, 0, 0, 0); chk(v, 8'h11);
    av(1, IDX_AUX_CTRL, 8'h12);
    av(1, IDX_STACK_PAGE, 8'h02);
    av(1, IDX_STACK_PTR, 8'hff);
    n1 = n_ext;
    core(REQ_PUSH, 1, 0, 8'h33);
    chk(n, n0 + 1);
    av(0, IDX_STACK_PTR, 0); chk(v, 8'h00);
    av(0, IDX_STACK_PAGE, 0); chk(v, 8'h02);
    av(1, IDX_STACK_PAGE, 8'h03);
    av(1, IDX_STACK_PTR, 8'hff);
    core(REQ_PUSH, 1, 0, 8'h44);
    av(1, IDX_STACK_PAGE, 8'h02);
    core(REQ_POP, 0, 0, 0); chk(v, 8'h33);
    chk(n_ext, n1);
    av(1, IDX_AUX_CTRL, 8'h00);
    $display("test stack done");
  endtask : t_stack
  task automatic t_iap;
    logic [7:0] mc [5] = '{8'h80, 8'h84, 8'h08, 8'h04, 8'h00};
    logic [15:0] ad [5] = '{16'h1234, 16'h0234, 16'h1234, 16'h0123, 16'h4321};
    nv_space_e es [5] = '{NV_CODE, NV_SIG, NV_FLASH_DATA, NV_SIG, NV_CODE};
    for (int i = 0; i < 5; i++) begin
      av(1, IDX_MEM_CTRL, mc[i]);
      av(0, IDX_MEM_CTRL, 0); chk(v, mc[i]);
      n1 = n_idle;
      core(i < 3 ? REQ_XMOVE_DPTR : REQ_CODE_READ, i < 3, ad[i], 8'h6e);
      chk(sp, es[i]);
      chk(n_idle != n1, i < 2);
      if (i > 2) chk(v, ad[i][7:0] ^ 8'h5a);
    end
    fuse <= 1'b0;
    av(1, IDX_MEM_CTRL, 8'h80);
    av(0, IDX_MEM_CTRL, 0); chk(v, 8'h00);
    $display("test self programming done");
  endtask : t_iap
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_ext();
    t_map();
    t_stack();
    t_iap();
    final_report();
  end
endmodule : testbench
